// ===== rtl/hp_device.sv
// The placing of the registers and the AHB-Lite interface to the registers were left to the implementer.
`timescale 1ns/100ps
`include "hp_regs.svh"

// Function
// - Host-changed status bits each synchronised
// - Software reads host flags twice
// - Eight byte locations seen by host
// - Host registers unreachable from processor
// - Transmit and receive paths double buffered
// - Command vector raises chosen exception
// - Control register readable and writable
// - Receive enable gates request on full
// - DMA receive enable: processor to host
// - Transmit enable gates request on empty
// - DMA transmit enable: host to processor
// - Both clear: none; both set: either in interrupt mode, receive only in DMA
// - Host never sets both in DMA
// - Resets clear enables and flag zero
// - Control bit two reads zero
// - Flag zero host-only, mirrored to processor
// - Address sequencer selects data in DMA
// - Host polls or takes request interrupt
// - Mode bits pick interrupt or DMA size
module hp_device (
	hp_if.device              bus,
	input  wire logic         core_clk,
	input  wire logic         rst,
	input  wire logic         soft_rst,
	input  wire logic [23:0]  proc_tx_word,
	input  wire logic         proc_tx_write,
	input  wire logic         proc_rx_read,
	input  wire logic [1:0]   proc_flags,
	input  wire logic         exc_ack,
	output logic      [23:0]  proc_rx_word,
	output logic      [7:0]   proc_status,
	output logic      [5:0]   exc_vector
);
	import hp_pkg::*;

	// ----------------------------------------
	// State
	// ----------------------------------------
	hp_byte_t    ctrl_reg;
	hp_byte_t    cmd_vec_reg;
	hp_byte_t    ivec_reg;
	logic [23:0] txw_reg;
	logic [23:0] rxw_reg;
	logic [23:0] htx_reg;
	logic        rx_full_reg;
	logic        tx_empty_reg;
	logic        prx_full_reg;
	logic        ptx_empty_reg;
	logic [1:0]  cnt_reg;
	logic [7:0]  sync_reg;
	logic        req_reg;
	hp_byte_t    dout_reg;
	logic        doe_reg;
	logic        rx_full_next;
	logic        tx_empty_next;
	logic        prx_full_next;
	logic        ptx_empty_next;
	hp_byte_t    rd_mux;

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	// Mode bit decode
	wire hp_mode_e mode = hp_mode_e'(ctrl_reg[`HP_CTL_MODE_MSB:`HP_CTL_MODE_LSB]);
	wire           dma_on = (mode != HP_MODE_INT);
	wire           rx_req_en = ctrl_reg[`HP_CTL_RX_EN];
	wire           tx_req_en = ctrl_reg[`HP_CTL_TX_EN];
	wire           dma_acc = dma_on & bus.host_acknowledge_pin;
	wire           acc = bus.hp_access | dma_acc;
	wire [2:0]     addr = dma_acc ? {1'b1, cnt_reg} : bus.register_select_lines;
	wire           rd = dma_acc ? rx_req_en : bus.hp_read;
	wire           wr_en = acc & ~rd;
	wire           rd_en = acc & rd;
	wire hp_byte_t wd = bus.data_bus;
	wire           init_go = ctrl_reg[`HP_CTL_INIT] & ~dma_acc;
	wire           init_rx = init_go & rx_req_en;
	wire           init_tx = init_go & tx_req_en;
	wire           xfer_in = ~tx_empty_reg & ~prx_full_reg;
	wire           xfer_out = ~ptx_empty_reg & ~rx_full_reg;
	wire           wr_ctrl = wr_en & (addr == `HP_OFF_CTRL);
	wire           wr_cvr = wr_en & (addr == `HP_OFF_CMDVEC);
	wire           wr_low = wr_en & (addr == `HP_OFF_DLOW);
	wire           rd_low = rd_en & (addr == `HP_OFF_DLOW);
	wire           req_rx = rx_req_en & rx_full_reg;
	wire           req_tx = tx_req_en & tx_empty_reg;
	wire           req_int = req_rx | req_tx;
	wire           req_dma = rx_req_en ? rx_full_reg : req_tx;
	wire           req_cond = dma_on ? req_dma : req_int;
	wire [7:0]     stat_src = {dma_on, 2'b00, ctrl_reg[`HP_CTL_FLAG1], ctrl_reg[`HP_CTL_FLAG0],
		cmd_vec_reg[`HP_CMDVEC_PEND], ptx_empty_reg, prx_full_reg};
	wire hp_byte_t host_stat = {req_reg, 2'b00, proc_flags, tx_empty_reg & ~prx_full_reg, tx_empty_reg,
		rx_full_reg};

	// ----------------------------------------
	// Host read mux
	// ----------------------------------------
	// Eight-byte host map
	always_comb begin
		unique case (addr)
			`HP_OFF_CTRL:   rd_mux = ctrl_reg;
			`HP_OFF_CMDVEC: rd_mux = cmd_vec_reg;
			`HP_OFF_STAT:   rd_mux = host_stat;
			`HP_OFF_IVEC:   rd_mux = ivec_reg;
			`HP_OFF_DHIGH:  rd_mux = rxw_reg[23:16];
			`HP_OFF_DMID:   rd_mux = rxw_reg[15:8];
			`HP_OFF_DLOW:   rd_mux = rxw_reg[7:0];
			default:        rd_mux = 8'h00;
		endcase
	end

	// ----------------------------------------
	// Flag next values
	// ----------------------------------------
	always_comb begin
		rx_full_next   = rx_full_reg;
		tx_empty_next  = tx_empty_reg;
		prx_full_next  = prx_full_reg;
		ptx_empty_next = ptx_empty_reg;
		if (rd_low)
			rx_full_next = 1'b0;
		if (init_rx)
			rx_full_next = 1'b0;
		if (xfer_out)
			rx_full_next = 1'b1;
		if (wr_low)
			tx_empty_next = 1'b0;
		if (init_tx || xfer_in)
			tx_empty_next = 1'b1;
		if (proc_rx_read || init_tx)
			prx_full_next = 1'b0;
		if (xfer_in)
			prx_full_next = 1'b1;
		if (proc_tx_write)
			ptx_empty_next = 1'b0;
		if (init_rx || xfer_out)
			ptx_empty_next = 1'b1;
	end

	// ----------------------------------------
	// Control and vectors
	// ----------------------------------------
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			ctrl_reg <= 8'h00;
			cmd_vec_reg <= 8'h00;
			ivec_reg <= `HP_IVEC_RST;
		end else if (soft_rst) begin
			ctrl_reg <= 8'h00;
			cmd_vec_reg <= 8'h00;
		end else begin
			// Flag zero written by host only
			if (wr_ctrl)
				ctrl_reg <= wd & `HP_CTL_WMASK;
			else if (init_go)
				ctrl_reg[`HP_CTL_INIT] <= 1'b0;
			if (wr_cvr)
				cmd_vec_reg <= wd;
			else if (exc_ack)
				cmd_vec_reg[`HP_CMDVEC_PEND] <= 1'b0;
			if (wr_en && addr == `HP_OFF_IVEC)
				ivec_reg <= wd;
		end
	end

	// ----------------------------------------
	// Data path
	// ----------------------------------------
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			txw_reg      <= 24'h00_0000;
			rxw_reg      <= 24'h00_0000;
			htx_reg      <= 24'h00_0000;
			proc_rx_word <= 24'h00_0000;
		end else begin
			if (wr_en && addr == `HP_OFF_DHIGH)
				txw_reg[23:16] <= wd;
			if (wr_en && addr == `HP_OFF_DMID)
				txw_reg[15:8] <= wd;
			if (wr_low)
				txw_reg[7:0] <= wd;
			if (proc_tx_write)
				htx_reg <= proc_tx_word;
			if (xfer_in)
				proc_rx_word <= txw_reg;
			if (xfer_out)
				rxw_reg <= htx_reg;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			rx_full_reg   <= 1'b0;
			tx_empty_reg  <= 1'b1;
			prx_full_reg  <= 1'b0;
			ptx_empty_reg <= 1'b1;
		end else if (soft_rst) begin
			rx_full_reg   <= 1'b0;
			tx_empty_reg  <= 1'b1;
			prx_full_reg  <= 1'b0;
			ptx_empty_reg <= 1'b1;
		end else begin
			rx_full_reg   <= rx_full_next;
			tx_empty_reg  <= tx_empty_next;
			prx_full_reg  <= prx_full_next;
			ptx_empty_reg <= ptx_empty_next;
		end
	end

	// ----------------------------------------
	// DMA address counter
	// ----------------------------------------
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst)
			cnt_reg <= 2'b00;
		else if (soft_rst || init_go)
			cnt_reg <= mode;
		// Wrap to mode at last byte
		else if (dma_acc)
			cnt_reg <= (cnt_reg == 2'b11) ? mode : cnt_reg + 2'b01;
	end

	// ----------------------------------------
	// Host pins
	// ----------------------------------------
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			req_reg  <= 1'b0;
			dout_reg <= 8'h00;
			doe_reg  <= 1'b0;
		end else begin
			req_reg  <= req_cond;
			dout_reg <= rd_mux;
			doe_reg  <= rd_en;
		end
	end

	assign bus.host_request_pin = req_reg;
	assign bus.dev_d_o          = dout_reg;
	assign bus.dev_d_oe         = doe_reg;

	// ----------------------------------------
	// Processor-side status
	// ----------------------------------------
	// Processor sees only synced status
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			sync_reg    <= 8'h02;
			proc_status <= 8'h02;
			exc_vector  <= 6'h00;
		end else begin
			sync_reg    <= stat_src;
			proc_status <= sync_reg;
			exc_vector  <= cmd_vec_reg[5:0];
		end
	end

endmodule // hp_device

// ===== rtl/hp_regs.svh
`ifndef HP_REGS_SVH
`define HP_REGS_SVH

// ----------------------------------------
// Host-side byte map
// ----------------------------------------
`define HP_OFF_CTRL      3'h0
`define HP_OFF_CMDVEC    3'h1
`define HP_OFF_STAT      3'h2
`define HP_OFF_IVEC      3'h3
`define HP_OFF_DHIGH     3'h5
`define HP_OFF_DMID      3'h6
`define HP_OFF_DLOW      3'h7

// ----------------------------------------
// Control and vector fields
// ----------------------------------------
`define HP_CTL_RX_EN     0
`define HP_CTL_TX_EN     1
`define HP_CTL_FLAG0     3
`define HP_CTL_FLAG1     4
`define HP_CTL_MODE_LSB  5
`define HP_CTL_MODE_MSB  6
`define HP_CTL_INIT      7
`define HP_CTL_WMASK     8'hfb
`define HP_CMDVEC_PEND   7
`define HP_IVEC_RST      8'h00
`define HP_BUS_IDLE      8'hff

// ----------------------------------------
// Controller register map (AHB-Lite)
// ----------------------------------------
`define HP_AHB_CMD       4'h0
`define HP_AHB_STAT      4'h4
`define HP_CMD_RD        12
`define HP_CMD_DMA       13
`define HP_ST_BUSY       0
`define HP_ST_REQ        1

`endif

// ===== rtl/hp_pkg.sv
package hp_pkg;

	typedef enum logic [1:0] {
		HP_IDLE = 2'b00,
		HP_STRB = 2'b01,
		HP_WAIT = 2'b11
	} hp_state_e;

	typedef enum logic [1:0] {
		HP_MODE_INT = 2'b00,
		HP_MODE_D24 = 2'b01,
		HP_MODE_D16 = 2'b10,
		HP_MODE_D8  = 2'b11
	} hp_mode_e;

	typedef logic [7:0] hp_byte_t;

endpackage

// ===== rtl/hp_if.sv
`timescale 1ns/100ps

interface hp_if;
	logic          hp_access;
	logic          hp_read;
	logic [2:0]    register_select_lines;
	logic          host_acknowledge_pin;
	logic          host_request_pin;
	hp_pkg::hp_byte_t host_d_o;
	logic          host_d_oe;
	hp_pkg::hp_byte_t dev_d_o;
	logic          dev_d_oe;
	hp_pkg::hp_byte_t data_bus;

	// Shared byte lane
	assign data_bus = dev_d_oe ? dev_d_o : (host_d_oe ? host_d_o : 8'hff);

	modport device (
		input  hp_access,
		input  hp_read,
		input  register_select_lines,
		input  host_acknowledge_pin,
		input  data_bus,
		output host_request_pin,
		output dev_d_o,
		output dev_d_oe
	);

	modport host (
		output hp_access,
		output hp_read,
		output register_select_lines,
		output host_acknowledge_pin,
		output host_d_o,
		output host_d_oe,
		input  host_request_pin,
		input  data_bus
	);
endinterface

// ===== rtl/hp_host.sv
`timescale 1ns/100ps
`include "hp_regs.svh"

module hp_host (
	hp_if.host                bus,
	input  wire logic         core_clk,
	input  wire logic         rst,
	input  wire logic         hsel,
	input  wire logic [31:0]  haddr,
	input  wire logic [1:0]   htrans,
	input  wire logic         hwrite,
	input  wire logic [2:0]   hsize,
	input  wire logic [31:0]  hwdata,
	input  wire logic         hready,
	output logic              hreadyout,
	output logic      [31:0]  hrdata,
	output logic              hresp
);
	import hp_pkg::*;

	// ----------------------------------------
	// State
	// ----------------------------------------
	hp_state_e   state_reg;
	logic        wph_reg;
	logic [3:0]  waddr_reg;
	hp_byte_t    rdat_reg;
	logic        acc_reg;
	logic        rd_reg;
	logic        ack_reg;
	logic [2:0]  sel_reg;
	hp_byte_t    wdat_reg;
	logic        oe_reg;

	// ----------------------------------------
	// Bus decode
	// ----------------------------------------
	wire       aph = hsel & htrans[1] & hready;
	wire       idle = (state_reg == HP_IDLE);
	// Host access on its own order
	wire       go = wph_reg & (waddr_reg == `HP_AHB_CMD) & idle;
	wire       dma = hwdata[`HP_CMD_DMA];
	wire [31:0] stat = {16'h0000, rdat_reg, 6'h00, bus.host_request_pin, ~idle};

	// ----------------------------------------
	// AHB-Lite slave
	// ----------------------------------------
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			wph_reg   <= 1'b0;
			waddr_reg <= 4'h0;
			hrdata    <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			wph_reg   <= aph & hwrite;
			waddr_reg <= haddr[3:0];
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			if (aph && !hwrite)
				hrdata <= (haddr[3:0] == `HP_AHB_STAT) ? stat : 32'h0000_0000;
		end
	end

	// ----------------------------------------
	// Host port cycle
	// ----------------------------------------
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state_reg <= HP_IDLE;
			acc_reg   <= 1'b0;
			ack_reg   <= 1'b0;
			rd_reg    <= 1'b0;
			sel_reg   <= 3'h0;
			wdat_reg  <= 8'h00;
			oe_reg    <= 1'b0;
			rdat_reg  <= 8'h00;
		end else begin
			unique case (state_reg)
				HP_IDLE: begin
					if (go) begin
						state_reg <= HP_STRB;
						acc_reg   <= ~dma;
						ack_reg   <= dma;
						rd_reg    <= hwdata[`HP_CMD_RD];
						sel_reg   <= hwdata[10:8];
						wdat_reg  <= hwdata[7:0];
						oe_reg    <= ~hwdata[`HP_CMD_RD];
					end
				end
				HP_STRB: begin
					state_reg <= HP_WAIT;
					acc_reg   <= 1'b0;
					ack_reg   <= 1'b0;
					oe_reg    <= 1'b0;
				end
				HP_WAIT: begin
					state_reg <= HP_IDLE;
					if (rd_reg)
						rdat_reg <= bus.data_bus;
				end
			endcase
		end
	end

	assign bus.hp_access             = acc_reg;
	assign bus.host_acknowledge_pin  = ack_reg;
	assign bus.hp_read               = rd_reg;
	assign bus.register_select_lines = sel_reg;
	assign bus.host_d_o              = wdat_reg;
	assign bus.host_d_oe             = oe_reg;

endmodule // hp_host

// ===== verif/hp_props.sv
`timescale 1ns/100ps
`include "hp_regs.svh"

module hp_props (
	input wire logic             core_clk,
	input wire logic             rst,
	input wire logic             hp_access,
	input wire logic             hp_read,
	input wire logic [2:0]       register_select_lines,
	input wire logic             host_acknowledge_pin,
	input wire logic             host_request_pin,
	input wire hp_pkg::hp_byte_t host_d_o,
	input wire logic             host_d_oe,
	input wire hp_pkg::hp_byte_t dev_d_o,
	input wire logic             dev_d_oe,
	input wire hp_pkg::hp_byte_t data_bus
);
	import hp_pkg::*;

	// ----------------------------------------
	// Enable tracking
	// ----------------------------------------
	logic en_clr;
	wire  ctl_wr = hp_access && !hp_read && register_select_lines == `HP_OFF_CTRL;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			en_clr <= 1'b1;
		end else if (ctl_wr) begin
			en_clr <= (data_bus[1:0] == 2'b00);
		end
	end

	// ----------------------------------------
	// Properties
	// ----------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	property p_rd_answer;
		hp_access && hp_read |=> dev_d_oe && data_bus == dev_d_o;
	endproperty
	a_rd_answer: assert property (p_rd_answer) else $error("read not answered");

	property p_oe_one;
		dev_d_oe |=> !dev_d_oe;
	endproperty
	a_oe_one: assert property (p_oe_one) else $error("device drive too long");

	property p_oe_cause;
		dev_d_oe |-> $past(hp_access && hp_read) || $past(host_acknowledge_pin) || $past(host_acknowledge_pin, 2);
	endproperty
	a_oe_cause: assert property (p_oe_cause) else $error("device drive without cause");

	property p_no_clash;
		!(dev_d_oe && host_d_oe);
	endproperty
	a_no_clash: assert property (p_no_clash) else $error("both drive lane");

	property p_host_oe;
		host_d_oe |-> ((hp_access && !hp_read) || host_acknowledge_pin) && data_bus == host_d_o;
	endproperty
	a_host_oe: assert property (p_host_oe) else $error("host drive outside write");

	property p_spacing;
		hp_access |=> !hp_access [*2];
	endproperty
	a_spacing: assert property (p_spacing) else $error("strobes too close");

	property p_bit2_zero;
		hp_access && hp_read && register_select_lines == `HP_OFF_CTRL |=> dev_d_o[2] == 1'b0;
	endproperty
	a_bit2_zero: assert property (p_bit2_zero) else $error("control bit 2 not zero");

	property p_off4_zero;
		hp_access && hp_read && register_select_lines == 3'h4 |=> dev_d_o == 8'h00;
	endproperty
	a_off4_zero: assert property (p_off4_zero) else $error("offset 4 not zero");

	property p_req_off;
		en_clr && $past(en_clr) && $past(en_clr, 2) |-> !host_request_pin;
	endproperty
	a_req_off: assert property (p_req_off) else $error("request with enables clear");
endmodule // hp_props

// ===== verif/host_port_host_side_control_test.sv
`timescale 1ns/100ps
`include "hp_regs.svh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin bad_count++; $display("BAD t=%0t got %h exp %h", $time, g, e); end end

module host_port_host_side_control_test;
	import hp_pkg::*;

	// ----------------------------------------
	// Signals and instances
	// ----------------------------------------
	logic        core_clk = 1'b0;
	logic        rst, soft_rst, proc_tx_write, proc_rx_read, exc_ack;
	logic [23:0] proc_tx_word, proc_rx_word;
	logic [1:0]  proc_flags, htrans;
	logic [7:0]  proc_status;
	logic [5:0]  exc_vector;
	logic        hsel, hwrite, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata;
	logic [2:0]  hsize;
	int          bad_count, n_compared;
	hp_byte_t    b;

	hp_if hp_bus ();
	hp_device hp_device_inst (.bus(hp_bus), .core_clk(core_clk), .rst(rst), .soft_rst(soft_rst),
		.proc_tx_word(proc_tx_word), .proc_tx_write(proc_tx_write), .proc_rx_read(proc_rx_read),
		.proc_flags(proc_flags), .exc_ack(exc_ack), .proc_rx_word(proc_rx_word),
		.proc_status(proc_status), .exc_vector(exc_vector));
	hp_host hp_host_inst (.bus(hp_bus), .core_clk(core_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp));
	hp_props hp_props_inst (.core_clk(core_clk), .rst(rst), .hp_access(hp_bus.hp_access),
		.hp_read(hp_bus.hp_read), .register_select_lines(hp_bus.register_select_lines),
		.host_acknowledge_pin(hp_bus.host_acknowledge_pin), .host_request_pin(hp_bus.host_request_pin),
		.host_d_o(hp_bus.host_d_o), .host_d_oe(hp_bus.host_d_oe), .dev_d_o(hp_bus.dev_d_o),
		.dev_d_oe(hp_bus.dev_d_oe), .data_bus(hp_bus.data_bus));

	always #2.5 core_clk = ~core_clk;

	// ----------------------------------------
	// Bus tasks
	// ----------------------------------------
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask

	task automatic ahb(input logic [31:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
		@(posedge core_clk);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'b10;
		hwrite <= w;
		do @(posedge core_clk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hsel <= 1'b0;
		hwdata <= d;
		do @(posedge core_clk); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask

	function automatic logic [31:0] cmd(input logic dma, input logic rd, input logic [2:0] off, input hp_byte_t v);
		return {18'h0, dma, rd, 1'b0, off, v};
	endfunction

	task automatic hp_op(input logic [31:0] c, output hp_byte_t v);
		logic [31:0] s;
		ahb(`HP_AHB_CMD, 1'b1, c, s);
		do ahb(`HP_AHB_STAT, 1'b0, 32'h0, s); while (s[`HP_ST_BUSY] !== 1'b0);
		v = s[15:8];
	endtask

	task automatic proc_tx(input logic [23:0] w);
		@(posedge core_clk);
		proc_tx_word <= w;
		proc_tx_write <= 1'b1;
		@(posedge core_clk);
		proc_tx_write <= 1'b0;
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_ctrl();
		`CHK(proc_status, 8'h02)
		hp_op(cmd(0, 1, `HP_OFF_CTRL, 0), b);
		`CHK(b, 8'h00)
		hp_op(cmd(0, 0, `HP_OFF_CTRL, 8'h1f), b);
		hp_op(cmd(0, 1, `HP_OFF_CTRL, 0), b);
		`CHK(b, 8'h1b)
		cyc(3);
		`CHK(proc_status[4:3], 2'b11)
		`CHK(hp_bus.host_request_pin, 1'b1)
		hp_op(cmd(0, 1, `HP_OFF_STAT, 0), b);
		`CHK(b[4:3], 2'b10)
		hp_op(cmd(0, 0, `HP_OFF_IVEC, 8'h5a), b);
		hp_op(cmd(0, 1, `HP_OFF_IVEC, 0), b);
		`CHK(b, 8'h5a)
		hp_op(cmd(0, 1, 3'h4, 0), b);
		`CHK(b, 8'h00)
		`CHK(hresp, 1'b0)
	endtask

	task automatic t_gate();
		logic [23:0] w;
		w = 24'h12_3456;
		hp_op(cmd(0, 0, `HP_OFF_CTRL, 8'h00), b);
		cyc(3);
		`CHK(hp_bus.host_request_pin, 1'b0)
		hp_op(cmd(0, 0, `HP_OFF_CTRL, 8'h02), b);
		cyc(3);
		`CHK(hp_bus.host_request_pin, 1'b1)
		hp_op(cmd(0, 0, `HP_OFF_CTRL, 8'h00), b);
		proc_tx(w);
		cyc(5);
		`CHK(hp_bus.host_request_pin, 1'b0)
		hp_op(cmd(0, 0, `HP_OFF_CTRL, 8'h01), b);
		cyc(3);
		`CHK(hp_bus.host_request_pin, 1'b1)
		for (int i = 0; i < 3; i++) begin
			hp_op(cmd(0, 1, 3'(`HP_OFF_DHIGH + i), 0), b);
			`CHK(b, w[23 - 8 * i -: 8])
		end
		cyc(3);
		`CHK(hp_bus.host_request_pin, 1'b0)
	endtask

	task automatic t_rx();
		logic [23:0] w;
		w = 24'hab_cdef;
		for (int i = 0; i < 3; i++) begin
			hp_op(cmd(0, 0, 3'(`HP_OFF_DHIGH + i), w[23 - 8 * i -: 8]), b);
		end
		cyc(5);
		`CHK(proc_rx_word, w)
		`CHK(proc_status[0], 1'b1)
		@(posedge core_clk);
		proc_rx_read <= 1'b1;
		@(posedge core_clk);
		proc_rx_read <= 1'b0;
	endtask

	task automatic t_cmd();
		logic [5:0] v;
		for (int i = 0; i < 2; i++) begin
			v = i ? 6'h00 : 6'h3f;
			hp_op(cmd(0, 0, `HP_OFF_CMDVEC, {2'b10, v}), b);
			cyc(4);
			`CHK(exc_vector, v)
			`CHK(proc_status[2], 1'b1)
			@(posedge core_clk);
			exc_ack <= 1'b1;
			@(posedge core_clk);
			exc_ack <= 1'b0;
			cyc(4);
			`CHK(proc_status[2], 1'b0)
		end
	endtask

	task automatic t_soft();
		hp_op(cmd(0, 0, `HP_OFF_CTRL, 8'h0b), b);
		@(posedge core_clk);
		soft_rst <= 1'b1;
		@(posedge core_clk);
		soft_rst <= 1'b0;
		hp_op(cmd(0, 1, `HP_OFF_CTRL, 0), b);
		`CHK(b, 8'h00)
		cyc(3);
		`CHK(proc_status[3], 1'b0)
	endtask

	task automatic t_dma();
		logic [23:0] w;
		w = 24'h9a_bcde;
		for (int m = 1; m < 4; m++) begin
			hp_op(cmd(0, 0, `HP_OFF_CTRL, {1'b1, 2'(m), 5'h01}), b);
			proc_tx(w);
			cyc(5);
			`CHK(hp_bus.host_request_pin, 1'b1)
			`CHK(proc_status[7], 1'b1)
			for (int o = 4 + m; o < 8; o++) begin
				hp_op(cmd(1, 1, 3'h0, 0), b);
				`CHK(b, w[8 * (7 - o) +: 8])
			end
			cyc(3);
			`CHK(hp_bus.host_request_pin, 1'b0)
		end
		w = 24'h35_79bd;
		hp_op(cmd(0, 0, `HP_OFF_CTRL, 8'ha2), b);
		cyc(3);
		`CHK(hp_bus.host_request_pin, 1'b1)
		for (int o = 5; o < 8; o++) begin
			hp_op(cmd(1, 0, 3'h0, w[8 * (7 - o) +: 8]), b);
		end
		cyc(5);
		`CHK(proc_rx_word, w)
		`CHK(proc_status[0], 1'b1)
		@(posedge core_clk);
		proc_rx_read <= 1'b1;
		@(posedge core_clk);
		proc_rx_read <= 1'b0;
	endtask

	task automatic finish_test();
		$display("mismatches %0d comparisons %0d", bad_count, n_compared);
		if (bad_count == 0 && n_compared > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// ----------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------
	initial begin
		rst = 1'b1;
		{soft_rst, proc_tx_write, proc_rx_read, exc_ack, hsel, hwrite} = 6'h00;
		proc_tx_word = 24'h0;
		proc_flags = 2'b10;
		htrans = 2'b00;
		hsize = 3'b010;
		haddr = 32'h0;
		hwdata = 32'h0;
		repeat (10) @(posedge core_clk);
		rst <= 1'b0;
		cyc(1);
		t_ctrl();
		t_gate();
		t_rx();
		t_cmd();
		t_soft();
		t_dma();
		finish_test();
	end

	initial begin
		#100000;
		bad_count++;
		finish_test();
	end
endmodule // host_port_host_side_control_test
